// file: iscc_defines.svh
// Constants for the instrument status and serial line configuration block.
`ifndef ISCC_DEFINES_SVH
`define ISCC_DEFINES_SVH

// ****************************************
// Register numbers
// ****************************************
`define ISCC_REG_CFG 16'h23f1
`define ISCC_REG_MAXBAUD 16'h23f4
`define ISCC_REG_GOOD_HI 16'h23f6
`define ISCC_REG_GOOD_LO 16'h23f7
`define ISCC_REG_BAD 16'h23f8
`define ISCC_REG_EXC 16'h23f9
`define ISCC_REG_MAXPROBE 16'h2451
`define ISCC_REG_PROBE_HI 16'h2452
`define ISCC_REG_PROBE_LO 16'h2453
`define ISCC_REG_MAXSENS 16'h2454
`define ISCC_REG_SENS_HI 16'h2455
`define ISCC_REG_SENS_LO 16'h2456

// ****************************************
// Configuration word fields and reset value
// ****************************************
`define ISCC_CFG_MODE_BIT 0
`define ISCC_CFG_BAUD_LSB 1
`define ISCC_CFG_DATA_BIT 4
`define ISCC_CFG_PAR_LSB 5
`define ISCC_CFG_STOP_BIT 7
`define ISCC_CFG_RESET 16'h0012
`define ISCC_PAR_NONE 2'h2

// ****************************************
// Exception codes, address and baud limits
// ****************************************
`define ISCC_EXC_DATA_VALUE 8'h03
`define ISCC_EXC_RTU_7BIT 8'h84
`define ISCC_EXC_NONE 8'h00
`define ISCC_ADDR_MAX 8'hf7
`define ISCC_MIN_BAUD_ID 3'h1

`endif

// file: iscc_pkg.sv
// Types for the instrument status and serial line configuration block.
`default_nettype none
package iscc_pkg;
  typedef enum logic [1:0] {
    ISCC_PAR_EVEN = 2'b00,
    ISCC_PAR_ODD = 2'b01,
    ISCC_PAR_NO = 2'b10
  } iscc_parity_t;

  // Fields run from bit 7 down to bit 0 of the configuration word.
  typedef struct packed {
    logic two_stop;
    logic [1:0] parity;
    logic eight_bits;
    logic [2:0] baud_id;
    logic ascii_mode;
  } iscc_line_t;

  typedef enum logic [1:0] {
    ISCC_ST_IDLE = 2'b00,
    ISCC_ST_PEND = 2'b01,
    ISCC_ST_SWAP = 2'b10
  } iscc_cfg_state_t;
endpackage
`default_nettype wire

// file: iscc_sat_counter.sv
// Saturating diagnostic message counter with software clear.
`timescale 1ns/1ns
`default_nettype none
module iscc_sat_counter #(
  parameter int WIDTH = 16
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Control.
  input wire logic inc_in,
  input wire logic clr_in,
  // Count.
  output logic [WIDTH-1:0] count_out
);
  initial begin
    if (WIDTH < 2) begin
      $error("iscc_sat_counter: WIDTH too small");
    end
  end

  // An increment in the clear cycle is kept, so no event is lost.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_out <= '0;
    end else if (clr_in) begin
      count_out <= {{(WIDTH-1){1'b0}}, inc_in};
    end else if (inc_in && !(&count_out)) begin
      count_out <= count_out + 1'b1;
    end
  end

  a_count_holds_full: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (&count_out && !clr_in) |=> &count_out)
    else $error("counter left saturation without clear");
endmodule // iscc_sat_counter
`default_nettype wire

// file: iscc_status_or.sv
// Reduction of per-sensor status words into the shared sensor status byte.
`timescale 1ns/1ns
`default_nettype none
module iscc_status_or #(
  parameter int NUM_SENS = 32
) (
  // Sensor status words, eight bits per connection.
  input wire logic [NUM_SENS*8-1:0] sens_stat_in,
  input wire logic [NUM_SENS-1:0] sens_active_in,
  // Combined byte.
  output logic [7:0] or_out
);
  initial begin
    if (NUM_SENS < 1 || NUM_SENS > 32) begin
      $error("iscc_status_or: NUM_SENS out of range");
    end
  end

  // Bits 6 and 7 are reserved and read zero.
  always_comb begin
    or_out = 8'h00;
    for (int i = 0; i < NUM_SENS; i++) begin
      if (sens_active_in[i]) begin
        or_out = or_out | sens_stat_in[i*8 +: 8];
      end
    end
    or_out[7:6] = 2'b00;
  end
endmodule // iscc_status_or
`default_nettype wire

// file: iscc_top.sv
// Status, serial line configuration and diagnostic register logic.
// Summary of operation
// - Status bits 0-7 OR sensor status bits.
// - Low status bits: alarms, warnings; 6-7 reserved.
// - Bits 8-14 common device conditions; 15 reserved.
// - Unused common status bits read zero.
// - Unused device-specific bits 16-31 read zero.
// - Config bit 0 picks RTU or ASCII.
// - Config bits 1-3 hold baud identifier.
// - Data bits, parity, stop bits fields.
// - Reply at old settings, then switch.
// - Support 9600 up to maximum baud id.
// - Unsupported baud write gets exception 3.
// - RTU with seven bits at a supported baud gets exception 0x84.
// - RTU 8E1 always; ASCII 7E1 when offered.
// - Counters never wrap; only host clears.
// - Good counter counts well formed local messages.
// - Bad counter counts malformed messages.
// - Exception counter counts exception replies.
// - Gateway maps up to 32 probe addresses.
// - Probe bit n answers at address+n+1.
// - Own address plus probes within 247.
// - Report sensor image count and status.
// - Read-only maximum baud identifier register.
`timescale 1ns/1ns
`default_nettype none
`include "iscc_defines.svh"
module iscc_top #(
  parameter int NUM_SENS = 32,
  parameter int NUM_PROBE = 32,
  parameter logic [2:0] MAX_BAUD_ID = 3'h3,
  parameter logic ASCII_OK = 1'b1,
  parameter logic [7:0] COMMON_USED = 8'h7f,
  parameter logic [15:0] SPECIFIC_USED = 16'h0000
) (
  // Clock and reset.
  input wire logic REF_CLK_IN,
  input wire logic RST_B_IN,
  // Register access from the protocol engine.
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [15:0] REG_NUM_IN,
  input wire logic [15:0] REG_WDATA_IN,
  output logic [15:0] REG_RDATA_OUT,
  output logic REG_ACK_OUT,
  output logic [7:0] REG_EXC_OUT,
  // Message events.
  input wire logic MSG_GOOD_IN,
  input wire logic MSG_BAD_IN,
  input wire logic MSG_EXC_IN,
  input wire logic RESP_DONE_IN,
  input wire logic [2:0] CNT_CLR_IN,
  // Status sources.
  input wire logic [NUM_SENS*8-1:0] SENS_STAT_IN,
  input wire logic [NUM_SENS-1:0] SENS_ACTIVE_IN,
  input wire logic [7:0] COMMON_STAT_IN,
  input wire logic [15:0] SPECIFIC_STAT_IN,
  input wire logic [NUM_PROBE-1:0] PROBE_LINK_IN,
  // Gateway addressing.
  input wire logic [7:0] OWN_ADDR_IN,
  input wire logic [7:0] RX_ADDR_IN,
  output logic ADDR_OWN_OUT,
  output logic ADDR_PROBE_OUT,
  output logic [4:0] PROBE_PORT_OUT,
  output logic [7:0] OWN_ADDR_OK_OUT,
  // Status and active line settings.
  output logic [31:0] DEVICE_STATUS_OUT,
  output logic [15:0] LINE_CFG_OUT,
  output logic [5:0] SENS_COUNT_OUT
);
  import iscc_pkg::*;

  initial begin
    if (NUM_SENS < 1 || NUM_SENS > 32 || NUM_PROBE < 1 || NUM_PROBE > 32) begin
      $error("iscc_top: connection counts must be 1 to 32");
    end
    if (MAX_BAUD_ID < `ISCC_MIN_BAUD_ID) begin
      $error("iscc_top: 9600 and 19200 must both be supported");
    end
  end

  // ****************************************
  // Status word
  // ****************************************
  logic [7:0] sens_or;
  logic [31:0] status_nxt;

  iscc_status_or #(.NUM_SENS(NUM_SENS)) u_or (
    .sens_stat_in(SENS_STAT_IN),
    .sens_active_in(SENS_ACTIVE_IN),
    .or_out(sens_or)
  );

  // Bit 15 is reserved; unused common and specific bits are masked off.
  always_comb begin
    status_nxt[7:0] = sens_or;
    status_nxt[15:8] = COMMON_STAT_IN & COMMON_USED & 8'h7f;
    status_nxt[31:16] = SPECIFIC_STAT_IN & SPECIFIC_USED;
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      DEVICE_STATUS_OUT <= 32'h0;
    end else begin
      DEVICE_STATUS_OUT <= status_nxt;
    end
  end

  // ****************************************
  // Configuration write check
  // ****************************************
  function automatic logic [7:0] cfg_check(input logic [15:0] w);
    iscc_line_t l;
    l = w[7:0];
    if (l.baud_id > MAX_BAUD_ID) begin
      cfg_check = `ISCC_EXC_DATA_VALUE;
    end else if (!l.ascii_mode && !l.eight_bits) begin
      cfg_check = `ISCC_EXC_RTU_7BIT;
    end else if (l.ascii_mode && !ASCII_OK) begin
      cfg_check = `ISCC_EXC_DATA_VALUE;
    end else if (l.parity > `ISCC_PAR_NONE) begin
      cfg_check = `ISCC_EXC_DATA_VALUE;
    end else begin
      cfg_check = `ISCC_EXC_NONE;
    end
  endfunction

  function automatic logic is_reg(input logic [15:0] n, input logic [15:0] r);
    is_reg = (n == r);
  endfunction

  logic cfg_wr;
  logic [7:0] cfg_err;
  assign cfg_wr = REG_WR_IN && is_reg(REG_NUM_IN, `ISCC_REG_CFG);
  assign cfg_err = cfg_check(REG_WDATA_IN);

  // ****************************************
  // Deferred switch to new line settings
  // ****************************************
  iscc_cfg_state_t state_r;
  logic [15:0] cfg_r;
  logic [15:0] pend_r;

  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state_r <= ISCC_ST_IDLE;
    end else begin
      unique case (state_r)
        ISCC_ST_IDLE: begin
          if (cfg_wr && cfg_err == `ISCC_EXC_NONE) begin
            state_r <= ISCC_ST_PEND;
          end
        end
        ISCC_ST_PEND: begin
          if (RESP_DONE_IN) begin
            state_r <= ISCC_ST_SWAP;
          end
        end
        ISCC_ST_SWAP: begin
          state_r <= ISCC_ST_IDLE;
        end
        default: begin
          state_r <= ISCC_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      pend_r <= `ISCC_CFG_RESET;
    end else if (cfg_wr && cfg_err == `ISCC_EXC_NONE &&
                 state_r == ISCC_ST_IDLE) begin
      pend_r <= {8'h00, REG_WDATA_IN[7:0]};
    end
  end

  // Active settings change only after the reply has left the line.
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      cfg_r <= `ISCC_CFG_RESET;
    end else if (state_r == ISCC_ST_SWAP) begin
      cfg_r <= pend_r;
    end
  end

  assign LINE_CFG_OUT = cfg_r;

  sequence s_cfg_accept;
    cfg_wr && cfg_err == `ISCC_EXC_NONE && state_r == ISCC_ST_IDLE;
  endsequence

  sequence s_reply_sent;
    RESP_DONE_IN && state_r == ISCC_ST_PEND;
  endsequence

  a_cfg_old_kept: assert property (@(posedge REF_CLK_IN)
    disable iff (!RST_B_IN)
    s_cfg_accept |=> $stable(cfg_r) && state_r == ISCC_ST_PEND)
    else $error("settings changed before reply");

  a_cfg_switch: assert property (@(posedge REF_CLK_IN)
    disable iff (!RST_B_IN)
    s_reply_sent ##1 1'b1 |=> cfg_r == $past(pend_r))
    else $error("settings not switched after reply");

  // ****************************************
  // Register access answer
  // ****************************************
  logic [15:0] good_hi;
  logic [15:0] good_lo;
  logic [15:0] bad_cnt;
  logic [15:0] exc_cnt;
  logic [31:0] good_cnt;
  logic [15:0] rdata_nxt;
  logic [7:0] exc_nxt;
  logic [31:0] probe_vec;
  logic [31:0] sens_vec;

  assign good_hi = good_cnt[31:16];
  assign good_lo = good_cnt[15:0];
  assign probe_vec = 32'(PROBE_LINK_IN);
  assign sens_vec = 32'(SENS_ACTIVE_IN);

  always_comb begin
    rdata_nxt = 16'h0;
    exc_nxt = `ISCC_EXC_NONE;
    if (cfg_wr) begin
      exc_nxt = cfg_err;
    end else if (REG_RD_IN) begin
      unique case (REG_NUM_IN)
        `ISCC_REG_CFG: rdata_nxt = cfg_r;
        `ISCC_REG_MAXBAUD: rdata_nxt = {13'h0, MAX_BAUD_ID};
        `ISCC_REG_GOOD_HI: rdata_nxt = good_hi;
        `ISCC_REG_GOOD_LO: rdata_nxt = good_lo;
        `ISCC_REG_BAD: rdata_nxt = bad_cnt;
        `ISCC_REG_EXC: rdata_nxt = exc_cnt;
        `ISCC_REG_MAXPROBE: rdata_nxt = 16'(NUM_PROBE);
        `ISCC_REG_PROBE_HI: rdata_nxt = probe_vec[31:16];
        `ISCC_REG_PROBE_LO: rdata_nxt = probe_vec[15:0];
        `ISCC_REG_MAXSENS: rdata_nxt = {10'h0, SENS_COUNT_OUT};
        `ISCC_REG_SENS_HI: rdata_nxt = sens_vec[31:16];
        `ISCC_REG_SENS_LO: rdata_nxt = sens_vec[15:0];
        default: rdata_nxt = 16'h0;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      REG_RDATA_OUT <= 16'h0;
      REG_EXC_OUT <= `ISCC_EXC_NONE;
    end else begin
      REG_RDATA_OUT <= rdata_nxt;
      REG_EXC_OUT <= exc_nxt;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      REG_ACK_OUT <= 1'b0;
    end else begin
      REG_ACK_OUT <= REG_WR_IN || REG_RD_IN;
    end
  end

  a_baud_reject: assert property (@(posedge REF_CLK_IN)
    disable iff (!RST_B_IN)
    (cfg_wr && REG_WDATA_IN[3:1] > MAX_BAUD_ID) |=>
      REG_EXC_OUT == `ISCC_EXC_DATA_VALUE && REG_ACK_OUT)
    else $error("unsupported baud not rejected");

  a_rtu_seven: assert property (@(posedge REF_CLK_IN)
    disable iff (!RST_B_IN)
    (cfg_wr && REG_WDATA_IN[3:1] <= MAX_BAUD_ID && !REG_WDATA_IN[0] &&
     !REG_WDATA_IN[4]) |=> REG_EXC_OUT == `ISCC_EXC_RTU_7BIT)
    else $error("RTU with seven bits not rejected");

  a_maxbaud_read: assert property (@(posedge REF_CLK_IN)
    disable iff (!RST_B_IN)
    (REG_RD_IN && !cfg_wr && REG_NUM_IN == `ISCC_REG_MAXBAUD) |=>
      REG_RDATA_OUT == {13'h0, MAX_BAUD_ID})
    else $error("maximum baud id misread");

  // ****************************************
  // Diagnostic message counters
  // ****************************************
  iscc_sat_counter #(.WIDTH(32)) u_good (
    .clk_in(REF_CLK_IN),
    .rst_b_in(RST_B_IN),
    .inc_in(MSG_GOOD_IN),
    .clr_in(CNT_CLR_IN[0]),
    .count_out(good_cnt)
  );

  iscc_sat_counter #(.WIDTH(16)) u_bad (
    .clk_in(REF_CLK_IN),
    .rst_b_in(RST_B_IN),
    .inc_in(MSG_BAD_IN),
    .clr_in(CNT_CLR_IN[1]),
    .count_out(bad_cnt)
  );

  iscc_sat_counter #(.WIDTH(16)) u_exc (
    .clk_in(REF_CLK_IN),
    .rst_b_in(RST_B_IN),
    .inc_in(MSG_EXC_IN),
    .clr_in(CNT_CLR_IN[2]),
    .count_out(exc_cnt)
  );

  a_good_counts: assert property (@(posedge REF_CLK_IN)
    disable iff (!RST_B_IN)
    (MSG_GOOD_IN && !CNT_CLR_IN[0] && !(&good_cnt)) |=>
      good_cnt == $past(good_cnt) + 32'h1)
    else $error("good counter missed a message");

  a_bad_nowrap: assert property (@(posedge REF_CLK_IN)
    disable iff (!RST_B_IN)
    !CNT_CLR_IN[1] |=> bad_cnt >= $past(bad_cnt))
    else $error("bad counter wrapped");

  // ****************************************
  // Gateway address map
  // ****************************************
  logic [8:0] own_lim;
  logic [8:0] rx_off;

  // The own address is clamped so that every probe address fits.
  always_comb begin
    own_lim = 9'(`ISCC_ADDR_MAX) - 9'(NUM_PROBE);
    OWN_ADDR_OK_OUT = (9'(OWN_ADDR_IN) > own_lim) ? own_lim[7:0] :
                      OWN_ADDR_IN;
    rx_off = 9'(RX_ADDR_IN) - 9'(OWN_ADDR_OK_OUT) - 9'h1;
  end

  // Address own+n+1 selects probe port n when that port is linked.
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ADDR_OWN_OUT <= 1'b0;
      ADDR_PROBE_OUT <= 1'b0;
      PROBE_PORT_OUT <= 5'h0;
    end else begin
      ADDR_OWN_OUT <= (RX_ADDR_IN == OWN_ADDR_OK_OUT);
      ADDR_PROBE_OUT <= (RX_ADDR_IN > OWN_ADDR_OK_OUT) &&
                        (rx_off < 9'(NUM_PROBE)) &&
                        probe_vec[rx_off[4:0]];
      PROBE_PORT_OUT <= rx_off[4:0];
    end
  end

  a_own_limit: assert property (@(posedge REF_CLK_IN)
    disable iff (!RST_B_IN)
    9'(OWN_ADDR_OK_OUT) + 9'(NUM_PROBE) <= 9'(`ISCC_ADDR_MAX))
    else $error("own address leaves no room for probes");

  // ****************************************
  // Sensor image count
  // ****************************************
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      SENS_COUNT_OUT <= 6'h0;
    end else begin
      SENS_COUNT_OUT <= 6'($countones(SENS_ACTIVE_IN));
    end
  end
endmodule // iscc_top
`default_nettype wire

// file: iscc_host_model.sv
// Host model that issues register strobes and tracks its own line settings.
`timescale 1ns/1ns
`default_nettype none
`include "iscc_defines.svh"
module iscc_host_model (
  // Clock.
  input wire logic clk_in,
  // Register request.
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [15:0] reg_num_out,
  output logic [15:0] reg_wdata_out,
  // Register answer.
  input wire logic [15:0] reg_rdata_in,
  input wire logic reg_ack_in,
  input wire logic [7:0] reg_exc_in
);
  logic [15:0] host_cfg;
  logic [15:0] rdata;
  logic [7:0] exc;
  logic ok;

  initial begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_num_out = 16'h0000;
    reg_wdata_out = 16'h0000;
    host_cfg = 16'h0012;
    ok = 1'b0;
  end

  // One strobe, answer taken at the edge after the one that takes it.
  task automatic access(input logic wr, input logic [15:0] num,
                        input logic [15:0] data);
    reg_wr_out <= wr;
    reg_rd_out <= !wr;
    reg_num_out <= num;
    reg_wdata_out <= data;
    @(posedge clk_in);
    reg_wr_out <= 1'b0;
    reg_rd_out <= 1'b0;
    // Released lines do not keep the last value.
    reg_num_out <= ~num;
    reg_wdata_out <= ~data;
    @(negedge clk_in);
    ok = (reg_ack_in === 1'b1);
    rdata = reg_rdata_in;
    exc = reg_exc_in;
    @(posedge clk_in);
    if (wr && num == `ISCC_REG_CFG && ok && exc === 8'h00) begin
      host_cfg = data;
    end
  endtask
endmodule // iscc_host_model
`default_nettype wire

// file: instrument_status_comm_config_tb.sv
// Self-checking testbench for the status and line configuration block.
`timescale 1ns/1ns
`default_nettype none
`include "iscc_defines.svh"
module instrument_status_comm_config_tb;
  localparam int NS = 8;
  localparam logic [2:0] MAXB = 3'h3;
  logic clk, rst_b, good, bad, excp, done, ack, aown, aprobe, wr, rd;
  logic [2:0] clr;
  logic [NS*8-1:0] sstat, tstat;
  logic [NS-1:0] sact;
  logic [7:0] cstat, own, rx, exc, ownok;
  logic [15:0] spec, rdata, lcfg, num, wd, d, e;
  logic [31:0] plink, dstat, ex;
  logic [4:0] port;
  logic [5:0] scnt;
  int comparisons = 0;
  int miscompares = 0;
  int n;

  iscc_top #(.NUM_SENS(NS), .NUM_PROBE(32), .MAX_BAUD_ID(MAXB)) DUT (
    .REF_CLK_IN(clk), .RST_B_IN(rst_b), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_NUM_IN(num), .REG_WDATA_IN(wd), .REG_RDATA_OUT(rdata),
    .REG_ACK_OUT(ack), .REG_EXC_OUT(exc), .MSG_GOOD_IN(good),
    .MSG_BAD_IN(bad), .MSG_EXC_IN(excp), .RESP_DONE_IN(done),
    .CNT_CLR_IN(clr), .SENS_STAT_IN(sstat), .SENS_ACTIVE_IN(sact),
    .COMMON_STAT_IN(cstat), .SPECIFIC_STAT_IN(spec),
    .PROBE_LINK_IN(plink), .OWN_ADDR_IN(own), .RX_ADDR_IN(rx),
    .ADDR_OWN_OUT(aown), .ADDR_PROBE_OUT(aprobe), .PROBE_PORT_OUT(port),
    .OWN_ADDR_OK_OUT(ownok), .DEVICE_STATUS_OUT(dstat),
    .LINE_CFG_OUT(lcfg), .SENS_COUNT_OUT(scnt));

  iscc_host_model host (
    .clk_in(clk), .reg_wr_out(wr), .reg_rd_out(rd), .reg_num_out(num),
    .reg_wdata_out(wd), .reg_rdata_in(rdata), .reg_ack_in(ack),
    .reg_exc_in(exc));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [15:0] r, input logic [31:0] exp);
    host.access(1'b0, r, 16'h0000);
    chk(host.ok, 1'b1);
    chk(host.rdata, exp);
  endtask

  task automatic wr_cfg(input logic [15:0] v, input logic [7:0] ecode);
    host.access(1'b1, `ISCC_REG_CFG, v);
    chk(host.ok, 1'b1);
    chk(host.exc, ecode);
  endtask

  // The reply-done pulse is taken at one edge; new settings show after
  // the next one.
  task automatic done_chk(input logic [15:0] nv);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    @(negedge clk);
    chk(lcfg, e);
    @(posedge clk);
    @(negedge clk);
    chk(lcfg, nv & 16'h00ff);
    e = nv & 16'h00ff;
    @(posedge clk);
  endtask

  task automatic ev(input logic [2:0] m, input int cnt);
    {excp, bad, good} <= m;
    repeat (cnt) @(posedge clk);
    {excp, bad, good} <= 3'b000;
    @(posedge clk);
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic print_verdict();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    $display("BAD %0t run did not finish", $time);
    print_verdict();
  end

  initial begin
    {rst_b, good, bad, excp, done, clr} = '0;
    {sstat, sact, cstat, spec, plink, rx} = '0;
    own = 8'h05;
    e = 16'h0012;
    void'($urandom(32'h436f));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // ****************************************
    // Reset values and configuration writes
    // ****************************************
    chk(lcfg, 16'h0012);
    rd_chk(`ISCC_REG_MAXBAUD, MAXB);
    rd_chk(16'h270f, 0);
    for (int i = 0; i < 8; i++) begin
      d = {8'($urandom), 1'($urandom), 2'($urandom % 3), 1'b1, 3'(i),
           1'($urandom)};
      wr_cfg(d, (i > MAXB) ? 8'h03 : 8'h00);
      chk(lcfg, e);
      if (i <= MAXB) done_chk(d);
    end
    rd_chk(`ISCC_REG_CFG, e);
    wr_cfg(16'h0002, 8'h84);
    wr_cfg(16'h0072, 8'h03);
    wr_cfg(16'h0003, 8'h00);
    wr_cfg(16'h0094, 8'h00);
    done_chk(16'h0003);
    wr_cfg(16'h0012, 8'h00);
    done_chk(16'h0012);
    // ****************************************
    // Status words and gateway addressing
    // ****************************************
    for (int t = 0; t < 4; t++) begin
      ex = $urandom;
      for (int s = 0; s < NS; s++)
        tstat[s*8+:8] = 8'($urandom);
      sact <= ex[NS-1:0];
      sstat <= tstat;
      cstat <= 8'($urandom);
      spec <= 16'($urandom);
      plink <= $urandom | 32'h20;
      settle();
      ex = {16'h0000, 1'b0, cstat[6:0], 8'h00};
      for (int s = 0; s < NS; s++)
        if (sact[s]) ex[7:0] = ex[7:0] | (sstat[s*8+:8] & 8'h3f);
      chk(dstat, ex);
      chk(scnt, $countones(sact));
      @(posedge clk);
      rd_chk(`ISCC_REG_SENS_LO, sact);
      rd_chk(`ISCC_REG_MAXSENS, $countones(sact));
      rd_chk(`ISCC_REG_PROBE_HI, plink[31:16]);
      rd_chk(`ISCC_REG_PROBE_LO, plink[15:0]);
    end
    rd_chk(`ISCC_REG_MAXPROBE, 32);
    rx <= 8'h0b;
    settle();
    chk({aown, aprobe, port}, {2'b01, 5'h05});
    @(posedge clk);
    rx <= 8'h05;
    settle();
    chk({aown, aprobe}, 2'b10);
    @(posedge clk);
    own <= 8'hf0;
    settle();
    chk(ownok, 8'hd7);
    @(posedge clk);
    // ****************************************
    // Message counters
    // ****************************************
    n = 1 + $urandom % 20;
    ev(3'b001, n);
    rd_chk(`ISCC_REG_GOOD_HI, 0);
    rd_chk(`ISCC_REG_GOOD_LO, n);
    ev(3'b010, 3);
    rd_chk(`ISCC_REG_BAD, 3);
    ev(3'b100, 65540);
    rd_chk(`ISCC_REG_EXC, 16'hffff);
    clr <= 3'b100;
    @(posedge clk);
    clr <= 3'b000;
    rd_chk(`ISCC_REG_EXC, 0);
    // A bad message in the clear cycle must still be counted.
    clr <= 3'b010;
    bad <= 1'b1;
    @(posedge clk);
    clr <= 3'b000;
    bad <= 1'b0;
    @(posedge clk);
    rd_chk(`ISCC_REG_BAD, 1);
    print_verdict();
  end
endmodule // instrument_status_comm_config_tb
`default_nettype wire
